// [hdl/csd_consts.svh]
// Offsets, field positions and timing counts of the compare/adjust unit
`ifndef CSD_CONSTS_SVH
`define CSD_CONSTS_SVH
`define CSD_OFS_INSTR 8'h00
`define CSD_OFS_ACC 8'h04
`define CSD_OFS_FILE 8'h08
`define CSD_OFS_BANK 8'h0c
`define CSD_OFS_FLAGS 8'h10
`define CSD_OFS_INDEX 8'h14
`define CSD_OFS_STATUS 8'h18
`define CSD_OFS_EADDR 8'h1c
`define CSD_FLG_CARRY 0
`define CSD_FLG_HALF 1
`define CSD_FLG_EXT 2
`define CSD_FLG_TWOWORD 3
`define CSD_OPC_GT 7'h32
`define CSD_OPC_LT 7'h30
`define CSD_OPC_ADJ 16'h0007
`define CSD_INDEX_MAX 8'h5f
`define CSD_ACCESS_HI 4'hf
`define CSD_NIB_MAX 4'h9
`define CSD_BCD_FIX 4'h6
`define CSD_Q_LAST 2'h3
`define CSD_RESP_OK 2'h0
`define CSD_RESP_ERR 2'h2
`endif

// [hdl/csd_pkg.sv]
// Types shared by the compare/adjust unit and its bus
package csd_pkg;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } csd_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } csd_axi_rsp_t;
  typedef enum logic [1:0] {
    CSD_IDLE = 2'b00,
    CSD_PEND = 2'b01,
    CSD_EXEC = 2'b10,
    CSD_SKIP = 2'b11
  } csd_state_t;
  typedef enum logic [1:0] {
    CSD_OP_NONE = 2'b00,
    CSD_OP_GT = 2'b01,
    CSD_OP_LT = 2'b10,
    CSD_OP_ADJ = 2'b11
  } csd_op_t;
endpackage : csd_pkg

// [hdl/csd_exec.sv]
// Compare-skip and decimal-adjust execution unit with AXI4-Lite registers
`timescale 1ns/1ps
`include "csd_consts.svh"
// Function
// - Greater-than compare subtracts W from the byte, skips if f>W.
// - Less-than compare decodes from upper bits 0110 000a plus address.
// - Less-than compare skips only when the byte is strictly below W.
// - Compares change no flag and write no result anywhere.
// - A taken skip discards the next word and runs one no-op cycle.
// - Skipping a two-word instruction costs two no-op cycles.
// - A compare is one word, one cycle, two when it skips, three when it skips a two-word one.
// - Compare decodes Q1, reads Q2, processes Q3, no write in Q4.
// - Operand select 0 picks the access bank, 1 uses the bank select.
// - With select 0, extended set on and f<=95, greater-than compare uses indexed offset.
// - Decimal adjust adds 6 to low nibble if above 9 or half carry.
// - Decimal adjust has no operand, is one word and one cycle.
module csd_exec import csd_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire csd_axi_req_t axiReq,
  output csd_axi_rsp_t axiRsp
);
  typedef struct packed {
    csd_axi_rsp_t bus;
    csd_state_t st;
    logic [1:0] q;
    logic [15:0] instr;
    csd_op_t op;
    logic [7:0] acc;
    logic [7:0] fileData;
    logic [3:0] bank;
    logic carry;
    logic halfCarry;
    logic extEn;
    logic twoWord;
    logic [11:0] indexBase;
    logic [7:0] opnd;
    logic [7:0] result;
    logic resCarry;
    logic skip;
    logic [1:0] skipLeft;
    logic [1:0] cycles;
    logic [11:0] eaddr;
  } csd_regs_t;

  csd_regs_t r;
  csd_regs_t next_r;
  logic wrHit;
  logic rdHit;
  logic [31:0] wrWord;
  logic [8:0] adjLow;
  logic [8:0] adjFull;
  logic hiFix;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
      input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  // ----------------------------------------------------------------------
  // Decimal adjust arithmetic
  // ----------------------------------------------------------------------
  always_comb begin
    adjLow = {1'b0, r.opnd};
    if (r.opnd[3:0] > `CSD_NIB_MAX || r.halfCarry) begin
      adjLow = {1'b0, r.opnd} + {5'h00, `CSD_BCD_FIX};
    end
    hiFix = adjLow[7:4] > `CSD_NIB_MAX || r.carry || adjLow[8];
    adjFull = hiFix ? adjLow + {1'b0, `CSD_BCD_FIX, 4'h0} : adjLow;
  end

  // ----------------------------------------------------------------------
  // Bus handshakes and register file
  // ----------------------------------------------------------------------
  assign wrHit = r.bus.awready && axiReq.awvalid && axiReq.wvalid;
  assign rdHit = r.bus.arready && axiReq.arvalid;

  always_comb begin
    next_r = r;
    wrWord = 32'h0000_0000;
    next_r.bus.awready = axiReq.awvalid && axiReq.wvalid &&
      !r.bus.awready && !r.bus.bvalid;
    next_r.bus.wready = next_r.bus.awready;
    next_r.bus.arready = axiReq.arvalid && !r.bus.arready &&
      !r.bus.rvalid;
    if (r.bus.bvalid && axiReq.bready) begin
      next_r.bus.bvalid = 1'b0;
    end
    if (r.bus.rvalid && axiReq.rready) begin
      next_r.bus.rvalid = 1'b0;
    end
    if (wrHit) begin
      next_r.bus.bvalid = 1'b1;
      next_r.bus.bresp = `CSD_RESP_OK;
      unique case (axiReq.awaddr)
        `CSD_OFS_INSTR: begin
          wrWord = mergeBytes({16'h0000, r.instr}, axiReq.wdata,
            axiReq.wstrb);
          if (r.st == CSD_IDLE) begin
            next_r.instr = wrWord[15:0];
            next_r.st = CSD_PEND;
            next_r.skip = 1'b0;
            next_r.cycles = 2'h0;
          end
        end
        `CSD_OFS_ACC: begin
          wrWord = mergeBytes({24'h0, r.acc}, axiReq.wdata, axiReq.wstrb);
          if (r.st == CSD_IDLE) begin
            next_r.acc = wrWord[7:0];
          end
        end
        `CSD_OFS_FILE: begin
          wrWord = mergeBytes({24'h0, r.fileData}, axiReq.wdata,
            axiReq.wstrb);
          if (r.st == CSD_IDLE) begin
            next_r.fileData = wrWord[7:0];
          end
        end
        `CSD_OFS_BANK: begin
          wrWord = mergeBytes({28'h0, r.bank}, axiReq.wdata, axiReq.wstrb);
          if (r.st == CSD_IDLE) begin
            next_r.bank = wrWord[3:0];
          end
        end
        `CSD_OFS_FLAGS: begin
          wrWord = mergeBytes({28'h0, r.twoWord, r.extEn, r.halfCarry,
            r.carry}, axiReq.wdata, axiReq.wstrb);
          if (r.st == CSD_IDLE) begin
            next_r.carry = wrWord[`CSD_FLG_CARRY];
            next_r.halfCarry = wrWord[`CSD_FLG_HALF];
            next_r.extEn = wrWord[`CSD_FLG_EXT];
            next_r.twoWord = wrWord[`CSD_FLG_TWOWORD];
          end
        end
        `CSD_OFS_INDEX: begin
          wrWord = mergeBytes({20'h0, r.indexBase}, axiReq.wdata,
            axiReq.wstrb);
          if (r.st == CSD_IDLE) begin
            next_r.indexBase = wrWord[11:0];
          end
        end
        `CSD_OFS_STATUS, `CSD_OFS_EADDR: begin
          wrWord = 32'h0000_0000;
        end
        default: begin
          next_r.bus.bresp = `CSD_RESP_ERR;
        end
      endcase
    end
    if (rdHit) begin
      next_r.bus.rvalid = 1'b1;
      next_r.bus.rresp = `CSD_RESP_OK;
      unique case (axiReq.araddr)
        `CSD_OFS_INSTR: next_r.bus.rdata = {16'h0000, r.instr};
        `CSD_OFS_ACC: next_r.bus.rdata = {24'h0, r.acc};
        `CSD_OFS_FILE: next_r.bus.rdata = {24'h0, r.fileData};
        `CSD_OFS_BANK: next_r.bus.rdata = {28'h0, r.bank};
        `CSD_OFS_FLAGS: next_r.bus.rdata = {28'h0, r.twoWord, r.extEn,
          r.halfCarry, r.carry};
        `CSD_OFS_INDEX: next_r.bus.rdata = {20'h0, r.indexBase};
        `CSD_OFS_STATUS: next_r.bus.rdata = {26'h0, r.q, r.cycles,
          r.skip, r.st != CSD_IDLE};
        `CSD_OFS_EADDR: next_r.bus.rdata = {20'h0, r.eaddr};
        default: begin
          next_r.bus.rdata = 32'h0000_0000;
          next_r.bus.rresp = `CSD_RESP_ERR;
        end
      endcase
    end

    // --------------------------------------------------------------------
    // Four-phase sequencer
    // --------------------------------------------------------------------
    next_r.q = r.q + 2'h1;
    unique case (r.st)
      CSD_IDLE: begin
      end
      CSD_PEND: begin
        if (r.q == `CSD_Q_LAST) begin
          next_r.st = CSD_EXEC;
        end
      end
      CSD_EXEC: begin
        unique case (r.q)
          2'h0: begin
            if (r.instr[15:9] == `CSD_OPC_LT) begin
              next_r.op = CSD_OP_LT;
            end else if (r.instr[15:9] == `CSD_OPC_GT) begin
              next_r.op = CSD_OP_GT;
            end else if (r.instr == `CSD_OPC_ADJ) begin
              next_r.op = CSD_OP_ADJ;
            end else begin
              next_r.op = CSD_OP_NONE;
            end
            if (r.instr[8]) begin
              next_r.eaddr = {r.bank, r.instr[7:0]};
            end else if (r.extEn && r.instr[15:9] == `CSD_OPC_GT &&
                r.instr[7:0] <= `CSD_INDEX_MAX) begin
              next_r.eaddr = r.indexBase + {4'h0, r.instr[7:0]};
            end else if (r.instr[7:0] <= `CSD_INDEX_MAX) begin
              next_r.eaddr = {4'h0, r.instr[7:0]};
            end else begin
              next_r.eaddr = {`CSD_ACCESS_HI, r.instr[7:0]};
            end
          end
          2'h1: begin
            next_r.opnd = (r.op == CSD_OP_ADJ) ? r.acc : r.fileData;
          end
          2'h2: begin
            next_r.skip = (r.op == CSD_OP_GT && r.opnd > r.acc) ||
              (r.op == CSD_OP_LT && r.opnd < r.acc);
            next_r.result = adjFull[7:0];
            next_r.resCarry = hiFix || adjFull[8];
          end
          2'h3: begin
            if (r.op == CSD_OP_ADJ) begin
              next_r.acc = r.result;
              next_r.carry = r.resCarry;
            end
            next_r.cycles = 2'h1;
            if (r.skip) begin
              next_r.st = CSD_SKIP;
              next_r.skipLeft = r.twoWord ? 2'h2 : 2'h1;
            end else begin
              next_r.st = CSD_IDLE;
            end
          end
        endcase
      end
      CSD_SKIP: begin
        if (r.q == `CSD_Q_LAST) begin
          next_r.cycles = r.cycles + 2'h1;
          next_r.skipLeft = r.skipLeft - 2'h1;
          if (r.skipLeft == 2'h1) begin
            next_r.st = CSD_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign axiRsp = r.bus;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_GT_SKIP: assert property (
    r.st == CSD_EXEC && r.q == 2'h2 && r.op == CSD_OP_GT
    |=> r.skip == (r.opnd > r.acc)) else $error("greater skip wrong");
  AST_LT_SKIP: assert property (
    r.st == CSD_EXEC && r.q == 2'h2 && r.op == CSD_OP_LT
    |=> r.skip == (r.opnd < r.acc)) else $error("less skip wrong");
  AST_LT_DECODE: assert property (
    r.st == CSD_EXEC && r.q == 2'h0 && r.instr[15:9] == 7'h30
    |=> r.op == CSD_OP_LT) else $error("less decode wrong");
  AST_CMP_NO_WRITE: assert property (
    r.st == CSD_EXEC && r.q == 2'h3 && r.op inside {CSD_OP_GT, CSD_OP_LT}
    |=> $stable(r.acc) && $stable(r.carry)) else $error("compare wrote");
  AST_ONE_NOP: assert property (
    $rose(r.st == CSD_SKIP) && r.skipLeft == 2'h1
    |-> (r.st == CSD_SKIP) [*4] ##1 r.st == CSD_IDLE && r.cycles == 2'h2)
    else $error("single skip length wrong");
  AST_TWO_NOP: assert property (
    $rose(r.st == CSD_SKIP) && r.skipLeft == 2'h2
    |-> (r.st == CSD_SKIP) [*8] ##1 r.st == CSD_IDLE && r.cycles == 2'h3)
    else $error("double skip length wrong");
  AST_NOSKIP_ONE: assert property (
    r.st == CSD_EXEC && r.q == 2'h3 && !r.skip
    |=> r.st == CSD_IDLE && r.cycles == 2'h1) else $error("cycle count");
  AST_EXEC_Q1: assert property (
    $rose(r.st == CSD_EXEC) |-> r.q == 2'h0 ##4 r.st != CSD_EXEC)
    else $error("execute cycle misaligned");
  AST_BANK_SEL: assert property (
    r.st == CSD_EXEC && r.q == 2'h0 && r.instr[8]
    |=> r.eaddr == {r.bank, r.instr[7:0]}) else $error("bank address");
  AST_ADJ_LOW: assert property (
    r.st == CSD_EXEC && r.q == 2'h3 && r.op == CSD_OP_ADJ &&
    r.opnd[3:0] <= 4'h9 && !r.halfCarry
    |=> r.acc[3:0] == r.opnd[3:0]) else $error("low nibble changed");
  AST_ADJ_Q4: assert property (
    $changed(r.acc) && !$past(wrHit) |-> $past(r.st) == CSD_EXEC &&
    $past(r.q) == 2'h3) else $error("accumulator written off Q4");

  CV_GT: cover property (r.st == CSD_EXEC && r.skip && r.op == CSD_OP_GT);
  CV_LT: cover property (r.st == CSD_EXEC && r.skip && r.op == CSD_OP_LT);
  CV_TWO: cover property (r.st == CSD_SKIP && r.skipLeft == 2'h2);
  CV_ADJ: cover property (r.op == CSD_OP_ADJ && r.resCarry);
endmodule : csd_exec

// [sim/tb.sv]
// Self-checking bench for the compare/adjust execution unit
`timescale 1ns/1ps
`include "csd_consts.svh"
module tb import csd_pkg::*;;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic sysClk = 1'b0;
  logic rst = 1'b1;
  csd_axi_req_t axiReq = '0;
  csd_axi_rsp_t axiRsp;
  logic [31:0] rdData;
  logic [1:0] resp;
  logic [31:0] st, acc, flg, ea;
  int mismatches = 0;
  int nChecks = 0;

  always #25 sysClk = ~sysClk;

  csd_exec i_dut (.sys_clk(sysClk), .rst(rst), .axiReq(axiReq),
    .axiRsp(axiRsp));

  // --------------------------------------------------------------
  // Reporting
  // --------------------------------------------------------------
  task automatic test_done;
    if (mismatches == 0 && nChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stall;
    chk(32'h1, 32'h0);
    test_done();
  endtask : stall

  // --------------------------------------------------------------
  // Bus cycles
  // --------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int n;
    @(posedge sysClk);
    axiReq.awaddr <= a;
    axiReq.wdata <= d;
    axiReq.wstrb <= s;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    n = 0;
    do begin
      @(posedge sysClk);
      n++;
      if (axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1 && n < 64);
    if (n >= 64) stall();
    resp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge sysClk);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    n = 0;
    do begin
      @(posedge sysClk);
      n++;
      if (axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
    end while (axiRsp.rvalid !== 1'b1 && n < 64);
    if (n >= 64) stall();
    rdData = axiRsp.rdata;
    resp = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask : axi_rd

  // --------------------------------------------------------------
  // Instruction helpers
  // --------------------------------------------------------------
  task automatic setup(input logic [7:0] w, input logic [7:0] f,
      input logic [3:0] bank, input logic [3:0] fl, input logic [11:0] idx);
    axi_wr(`CSD_OFS_ACC, {24'h0, w}, 4'hf);
    axi_wr(`CSD_OFS_FILE, {24'h0, f}, 4'hf);
    axi_wr(`CSD_OFS_BANK, {28'h0, bank}, 4'hf);
    axi_wr(`CSD_OFS_FLAGS, {28'h0, fl}, 4'hf);
    axi_wr(`CSD_OFS_INDEX, {20'h0, idx}, 4'hf);
  endtask : setup

  task automatic run(input logic [15:0] ins);
    int n;
    axi_wr(`CSD_OFS_INSTR, {16'h0, ins}, 4'hf);
    n = 0;
    do begin
      axi_rd(`CSD_OFS_STATUS);
      n++;
    end while (rdData[0] !== 1'b0 && n < 32);
    if (n >= 32) stall();
    st = rdData;
    axi_rd(`CSD_OFS_ACC);
    acc = rdData;
    axi_rd(`CSD_OFS_FLAGS);
    flg = rdData;
    axi_rd(`CSD_OFS_EADDR);
    ea = rdData;
  endtask : run

  task automatic cmp_case(input logic [6:0] opc, input logic [7:0] f,
      input logic [7:0] w, input logic [3:0] fl, input logic sk);
    logic [1:0] cyc;
    cyc = !sk ? 2'h1 : (fl[3] ? 2'h3 : 2'h2);
    setup(w, f, 4'h2, fl, 12'h0);
    run({opc, 1'b1, 8'h10});
    chk({31'h0, st[1]}, {31'h0, sk});
    chk({30'h0, st[3:2]}, {30'h0, cyc});
    chk(acc, {24'h0, w});
    chk(flg, {28'h0, fl});
  endtask : cmp_case

  task automatic addr_case(input logic [6:0] opc, input logic a,
      input logic [7:0] f, input logic [3:0] fl, input logic [11:0] exp);
    setup(8'h00, 8'h00, 4'h5, fl, 12'h100);
    run({opc, a, f});
    chk(ea, {20'h0, exp});
  endtask : addr_case

  task automatic adj_case(input logic [7:0] w, input logic [3:0] fl,
      input logic [7:0] ew, input logic [3:0] ef);
    setup(w, 8'h00, 4'h0, fl, 12'h0);
    run(`CSD_OPC_ADJ);
    chk(acc, {24'h0, ew});
    chk(flg, {28'h0, ef});
    chk({29'h0, st[3:1]}, 32'h2);
  endtask : adj_case

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_bus;
    axi_rd(`CSD_OFS_ACC);
    chk(rdData, 32'h0);
    axi_rd(8'h20);
    chk({30'h0, resp}, {30'h0, `CSD_RESP_ERR});
    chk(rdData, 32'h0);
    axi_wr(8'h24, 32'h1, 4'hf);
    chk({30'h0, resp}, {30'h0, `CSD_RESP_ERR});
    axi_wr(`CSD_OFS_ACC, 32'hffffffab, 4'h0);
    axi_rd(`CSD_OFS_ACC);
    chk(rdData, 32'h0);
    axi_wr(`CSD_OFS_ACC, 32'hffffffab, 4'h1);
    axi_rd(`CSD_OFS_ACC);
    chk(rdData, 32'hab);
    axi_wr(`CSD_OFS_INDEX, 32'hffffffff, 4'hf);
    axi_rd(`CSD_OFS_INDEX);
    chk(rdData, 32'hfff);
    axi_wr(`CSD_OFS_STATUS, 32'hffffffff, 4'hf);
    chk({30'h0, resp}, {30'h0, `CSD_RESP_OK});
    axi_rd(`CSD_OFS_STATUS);
    chk({28'h0, rdData[3:0]}, 32'h0);
  endtask : t_bus

  task automatic t_greater;
    cmp_case(`CSD_OPC_GT, 8'h81, 8'h80, 4'h0, 1'b1);
    cmp_case(`CSD_OPC_GT, 8'h80, 8'h80, 4'h3, 1'b0);
    cmp_case(`CSD_OPC_GT, 8'h7f, 8'h80, 4'h0, 1'b0);
    cmp_case(`CSD_OPC_GT, 8'h80, 8'h7f, 4'hb, 1'b1);
    cmp_case(`CSD_OPC_GT, 8'hff, 8'h00, 4'h8, 1'b1);
  endtask : t_greater

  task automatic t_less;
    cmp_case(`CSD_OPC_LT, 8'h7f, 8'h80, 4'h0, 1'b1);
    cmp_case(`CSD_OPC_LT, 8'h80, 8'h80, 4'h0, 1'b0);
    cmp_case(`CSD_OPC_LT, 8'h81, 8'h80, 4'h3, 1'b0);
    cmp_case(`CSD_OPC_LT, 8'h00, 8'hff, 4'h8, 1'b1);
    cmp_case(`CSD_OPC_LT, 8'h80, 8'h7f, 4'h0, 1'b0);
  endtask : t_less

  task automatic t_address;
    addr_case(`CSD_OPC_GT, 1'b1, 8'h3c, 4'h0, 12'h53c);
    addr_case(`CSD_OPC_GT, 1'b0, 8'h3c, 4'h0, 12'h03c);
    addr_case(`CSD_OPC_GT, 1'b0, 8'ha0, 4'h0, 12'hfa0);
    addr_case(`CSD_OPC_GT, 1'b0, 8'h5f, 4'h4, 12'h15f);
    addr_case(`CSD_OPC_GT, 1'b0, 8'h60, 4'h4, 12'hf60);
    addr_case(`CSD_OPC_LT, 1'b0, 8'h3c, 4'h4, 12'h03c);
  endtask : t_address

  task automatic t_adjust;
    adj_case(8'ha5, 4'h0, 8'h05, 4'h1);
    adj_case(8'hce, 4'h0, 8'h34, 4'h1);
    adj_case(8'h19, 4'h2, 8'h1f, 4'h2);
    adj_case(8'h12, 4'h1, 8'h72, 4'h1);
    adj_case(8'h99, 4'h0, 8'h99, 4'h0);
    adj_case(8'h9a, 4'h0, 8'h00, 4'h1);
    adj_case(8'h12, 4'hc, 8'h12, 4'hc);
  endtask : t_adjust

  initial begin
    repeat (4) @(posedge sysClk);
    rst <= 1'b0;
    t_bus();
    t_greater();
    t_less();
    t_address();
    t_adjust();
    test_done();
  end
endmodule : tb
